// [common/ckgsel_pkg.sv]
// Package for the clock select, channel enable and interrupt gating block.
// Assumes a 32-bit AHB-Lite register bus and a 200 MHz system clock.
package ckgsel_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register indices; the byte address is four times the index
   localparam logic [9:0]  CLOCK_TREE_SELECT_IDX = 10'h003;
   localparam logic [9:0]  CHANNEL_ENABLE_IDX    = 10'h004;
   localparam logic [9:0]  INTERRUPT_GATING_IDX  = 10'h005;
   localparam logic [9:0]  IRQ_FLAG_CLEAR_IDX    = 10'h006;
   localparam logic [9:0]  IRQ_CONTROL_IDX       = 10'h00A;
   localparam logic [9:0]  MULTIPLIER_CTRL_IDX   = 10'h065;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [15:0] CLOCK_TREE_SELECT_RST = 16'h0000;
   localparam logic [15:0] CHANNEL_ENABLE_RST    = 16'h0000;
   localparam logic [15:0] INTERRUPT_GATING_RST  = 16'h007F;
   localparam logic [15:0] IRQ_CONTROL_RST       = 16'h0000;
   localparam logic [15:0] MULTIPLIER_CTRL_RST   = 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int REF_SEL_LSB   = 8;   // multiplier_reference_select [9:8]
   localparam int OUT_SEL_LSB   = 4;   // multiplier_output_code [6:4]
   localparam int SCALER_LSB    = 0;   // system_scaler_code [2:0]
   localparam int LEFT_EN_BIT   = 1;
   localparam int RIGHT_EN_BIT  = 0;
   localparam int DISABLE_LSB   = 0;   // disable bits [6:0]
   localparam int MASK_LSB      = 8;   // mask bits [14:8]
   localparam int POLARITY_BIT  = 0;
   localparam int MULT_EN_BIT   = 0;

   // Interrupt source positions in status, mask and disable fields
   localparam int SRC_SHUTDOWN  = 4;
   localparam int SRC_CLIP      = 3;
   localparam int SRC_UNDERVOLT = 2;
   localparam int SRC_POWERUP   = 0;
   localparam logic [6:0] SRC_USED = 7'h1D;

   ////////////////////////////////////////////////////////////////////////
   // Codes
   localparam logic [1:0] REF_OFF     = 2'h3;
   localparam logic [2:0] OUT_PIN     = 3'h0;
   localparam logic [2:0] OUT_X1      = 3'h1;
   localparam logic [2:0] OUT_X2      = 3'h2;
   localparam logic [2:0] OUT_X4      = 3'h3;
   localparam logic [2:0] OUT_X8      = 3'h4;
   localparam logic [2:0] SCALE_BYPAS = 3'h4;

   ////////////////////////////////////////////////////////////////////////
   // Timing: quiet gap on each side of a clock switch
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SWITCH_GAP_PS = 100000;
   localparam int SWITCH_GAP_CYC =
      (SWITCH_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {SW_RUN, SW_STOP, SW_LOAD} ckgsel_sw_t;

endpackage

// [hdl/ckgsel_top.sv]
// Clock tree control, output path enables and interrupt gating.
// Assumes an AHB-Lite master, asynchronous event inputs from the analog
// side and an analog clock tree that follows the decoded select outputs.
// The derived clock is built outside; the selects only move while the
// switch sequencer holds that clock stopped.
`timescale 1ns/1ps
module ckgsel_top
   import ckgsel_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Interrupt sources, asynchronous levels
   input  wire logic        shutdown_event,
   input  wire logic        clipping_event,
   input  wire logic        undervoltage_event,
   input  wire logic        powerup_event,
   // Clock tree controls
   output logic [1:0]       reference_divider_code,
   output logic             reference_on,
   output logic [4:0]       multiplied_clock_select,
   output logic [1:0]       system_scaler_shift,
   output logic             system_scaler_bypass,
   output logic             system_clock_run,
   // Output paths and interrupt pin
   output logic             left_path_enable,
   output logic             right_path_enable,
   output logic             irq_pin
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      // Event capture and latched status
      logic [3:0]  sync1;
      logic [3:0]  sync2;
      logic [3:0]  sync3;
      logic [3:0]  evt_lvl;
      logic [6:0]  status;
      // Register copies
      logic [15:0] clk_tree;
      logic [15:0] chan;
      logic [15:0] gating;
      logic [15:0] irq_ctl;
      logic [15:0] mult_ctl;
      // Clock switch sequencer
      logic [15:0] applied;
      logic        applied_men;
      ckgsel_sw_t  sw;
      logic [7:0]  gap_cnt;
      // Bus data phase
      logic        wr_pend;
      logic        rd_pend;
      logic [9:0]  dp_idx;
      logic        hready;
      logic [31:0] hrdata;
      // Registered outputs
      logic [1:0]  ref_code;
      logic        ref_on;
      logic [4:0]  mul_sel;
      logic [1:0]  sc_shift;
      logic        sc_bypass;
      logic        clk_run;
      logic        left_en;
      logic        right_en;
      logic        irq_pin;
   } ckgsel_state_t;

   // Last count of each quiet gap around a switch
   localparam logic [7:0] GAP_LAST = 8'(SWITCH_GAP_CYC - 1);

   // Current and next state
   ckgsel_state_t st_r;
   ckgsel_state_t st_nxt;

   // Event and interrupt nets
   logic [3:0]  evt_in;
   logic [3:0]  evt_stable;
   logic [3:0]  evt_rise;
   logic [6:0]  src_set;
   logic [6:0]  src_clr;
   logic [6:0]  irq_active_v;
   logic        irq_active;
   // Bus nets
   logic        take;
   logic [9:0]  ap_idx;
   logic [31:0] rd_val;
   // Fields of the applied clock selection
   logic [2:0]  out_code;
   logic [2:0]  sc_code;

   assign evt_in = {shutdown_event, clipping_event,
                    undervoltage_event, powerup_event};

   ////////////////////////////////////////////////////////////////////////
   // Event qualification: a change counts once stages two and three agree
   // and only falls back once both read low, so a glitch counts once
   assign evt_stable = (st_r.sync2 & st_r.sync3) |
                       (st_r.evt_lvl & (st_r.sync2 | st_r.sync3));
   assign evt_rise   = evt_stable & ~st_r.evt_lvl;

   // Map event order onto status bit positions
   always_comb
   begin
      src_set = 7'h00;
      src_set[SRC_SHUTDOWN]  = evt_rise[3];
      src_set[SRC_CLIP]      = evt_rise[2];
      src_set[SRC_UNDERVOLT] = evt_rise[1];
      src_set[SRC_POWERUP]   = evt_rise[0];
      // Disabled sources never latch
      src_set = src_set & ~st_r.gating[DISABLE_LSB +: 7] & SRC_USED;
   end

   // Masked sources latch but stay off the pin
   assign irq_active_v = st_r.status & ~st_r.gating[MASK_LSB +: 7];
   assign irq_active   = |irq_active_v;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   assign take   = hsel & hready & htrans[1];

   // Word index of the address phase
   assign ap_idx = haddr[11:2];

   // Read mux on the data-phase index
   always_comb
   begin
      rd_val = 32'h0000_0000;
      unique case (st_r.dp_idx)
         CLOCK_TREE_SELECT_IDX: rd_val[15:0] = st_r.clk_tree;
         CHANNEL_ENABLE_IDX:    rd_val[15:0] = st_r.chan;
         INTERRUPT_GATING_IDX:  rd_val[15:0] = st_r.gating;
         IRQ_FLAG_CLEAR_IDX:    rd_val[6:0]  = st_r.status;
         IRQ_CONTROL_IDX:       rd_val[15:0] = st_r.irq_ctl;
         MULTIPLIER_CTRL_IDX:   rd_val[15:0] = st_r.mult_ctl;
         default:               rd_val       = 32'h0000_0000;
      endcase
   end

   // Write-one-to-clear mask for the status bits
   // It acts in the data phase, while hwdata stands
   assign src_clr = (st_r.wr_pend && st_r.dp_idx == IRQ_FLAG_CLEAR_IDX)
                    ? hwdata[6:0] : 7'h00;

   // Fields of the clock selection now in force
   assign out_code = st_r.applied[OUT_SEL_LSB +: 3];
   assign sc_code  = st_r.applied[SCALER_LSB +: 3];

   ////////////////////////////////////////////////////////////////////////
   // Next state
   // Each field holds unless a group below changes it
   always_comb
   begin
      st_nxt = st_r;

      // Three-stage capture of the asynchronous events
      st_nxt.sync1   = evt_in;
      st_nxt.sync2   = st_r.sync1;
      st_nxt.sync3   = st_r.sync2;
      st_nxt.evt_lvl = evt_stable;

      // Set wins over a clear in the same cycle
      st_nxt.status = ((st_r.status & ~src_clr) | src_set) & SRC_USED;

      // Register writes in the data phase
      // The status word only clears, which is done above
      if (st_r.wr_pend)
      begin
         unique case (st_r.dp_idx)
            CLOCK_TREE_SELECT_IDX: st_nxt.clk_tree = hwdata[15:0];
            CHANNEL_ENABLE_IDX:    st_nxt.chan     = hwdata[15:0];
            INTERRUPT_GATING_IDX:  st_nxt.gating   = hwdata[15:0];
            IRQ_CONTROL_IDX:       st_nxt.irq_ctl  = hwdata[15:0];
            MULTIPLIER_CTRL_IDX:   st_nxt.mult_ctl = hwdata[15:0];
            default:               st_nxt.chan     = st_r.chan;
         endcase
      end

      // Reads take one wait state so a write just before is seen
      st_nxt.wr_pend = 1'b0;
      st_nxt.rd_pend = 1'b0;
      st_nxt.hready  = 1'b1;
      // Second read cycle: present the data
      if (st_r.rd_pend)
      begin
         st_nxt.hrdata = rd_val;
      end
      // Address phase: note what the data phase must do
      else if (take)
      begin
         st_nxt.dp_idx  = ap_idx;
         st_nxt.wr_pend = hwrite;
         st_nxt.rd_pend = ~hwrite;
         st_nxt.hready  = hwrite;
      end

      // Clock switch: stop, change selects, wait, restart
      unique case (st_r.sw)
         // Idle: any difference starts a switch
         SW_RUN:
         begin
            if (st_r.clk_tree != st_r.applied ||
                st_r.mult_ctl[MULT_EN_BIT] != st_r.applied_men)
            begin
               st_nxt.sw      = SW_STOP;
               st_nxt.clk_run = 1'b0;
               st_nxt.gap_cnt = 8'h00;
            end
         end
         // Stopped: load the new selects after the gap
         SW_STOP:
         begin
            st_nxt.gap_cnt = st_r.gap_cnt + 8'h01;
            if (st_r.gap_cnt == GAP_LAST)
            begin
               st_nxt.sw          = SW_LOAD;
               st_nxt.applied     = st_r.clk_tree;
               st_nxt.applied_men = st_r.mult_ctl[MULT_EN_BIT];
               st_nxt.gap_cnt     = 8'h00;
            end
         end
         // Loaded: let the selects settle, then restart
         SW_LOAD:
         begin
            st_nxt.gap_cnt = st_r.gap_cnt + 8'h01;
            if (st_r.gap_cnt == GAP_LAST)
            begin
               st_nxt.sw      = SW_RUN;
               st_nxt.clk_run = 1'b1;
            end
         end
      endcase

      // Reference feed for the multiplier
      st_nxt.ref_code = st_r.applied[REF_SEL_LSB +: 2];
      st_nxt.ref_on   = st_r.applied[REF_SEL_LSB +: 2] != REF_OFF;

      // Multiplier output choice, one-hot; x4/x8 need the enable
      st_nxt.mul_sel = 5'h00;
      unique case (out_code)
         OUT_PIN: st_nxt.mul_sel = 5'h01;
         OUT_X1:  st_nxt.mul_sel = 5'h02;
         OUT_X2:  st_nxt.mul_sel = 5'h04;
         OUT_X4:  st_nxt.mul_sel = st_r.applied_men ? 5'h08 : 5'h00;
         OUT_X8:  st_nxt.mul_sel = st_r.applied_men ? 5'h10 : 5'h00;
         default: st_nxt.mul_sel = 5'h00;
      endcase

      // System scaler: divide by 2^code or bypass to the pin
      st_nxt.sc_bypass = sc_code[2];
      st_nxt.sc_shift  = sc_code[2] ? 2'h0 : sc_code[1:0];

      // Output path enables
      st_nxt.left_en  = st_r.chan[LEFT_EN_BIT];
      st_nxt.right_en = st_r.chan[RIGHT_EN_BIT];

      // Interrupt pin level with programmable polarity
      // With polarity 0 the pin idles high
      st_nxt.irq_pin = st_r.irq_ctl[POLARITY_BIT] ? irq_active
                                                  : ~irq_active;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         // Idle bus, clock running, interrupt pin inactive
         st_r             <= '0;
         st_r.clk_tree    <= CLOCK_TREE_SELECT_RST;
         st_r.chan        <= CHANNEL_ENABLE_RST;
         st_r.gating      <= INTERRUPT_GATING_RST;
         st_r.irq_ctl     <= IRQ_CONTROL_RST;
         st_r.mult_ctl    <= MULTIPLIER_CTRL_RST;
         st_r.applied     <= CLOCK_TREE_SELECT_RST;
         st_r.sw          <= SW_RUN;
         st_r.hready      <= 1'b1;
         st_r.ref_on      <= 1'b1;
         st_r.mul_sel     <= 5'h01;
         st_r.clk_run     <= 1'b1;
         st_r.irq_pin     <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register, except hresp, which is tied to zero
   assign hrdata                  = st_r.hrdata;
   assign hreadyout               = st_r.hready;
   assign hresp                   = 1'b0;

   // Clock tree selects
   assign reference_divider_code  = st_r.ref_code;
   assign reference_on            = st_r.ref_on;
   assign multiplied_clock_select = st_r.mul_sel;
   assign system_scaler_shift     = st_r.sc_shift;
   assign system_scaler_bypass    = st_r.sc_bypass;
   assign system_clock_run        = st_r.clk_run;

   // Output paths and interrupt pin
   assign left_path_enable        = st_r.left_en;
   assign right_path_enable       = st_r.right_en;
   assign irq_pin                 = st_r.irq_pin;

endmodule

// [sim/ckgsel_chk.sv]
// Port assertions for the clock select and interrupt gating block.
// Assumes one clock domain and a single AHB-Lite master.
`timescale 1ns/1ps
module ckgsel_chk
   import ckgsel_pkg::*;
(
   // Clock, reset and bus
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       hresp,
   // Clock tree and interrupt pin
   input wire logic [1:0] reference_divider_code,
   input wire logic       reference_on,
   input wire logic [4:0] multiplied_clock_select,
   input wire logic [1:0] system_scaler_shift,
   input wire logic       system_scaler_bypass,
   input wire logic       system_clock_run,
   input wire logic       irq_pin
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Accepted transfer
   wire logic take = hsel && hready && htrans[1];
   ////////////////////////////////////////////////////////////////////////
   // Bus handshake
   bus_okay_a: assert property (hresp == 1'b0)
      else $error("response not okay");
   read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_nowait_a: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   ////////////////////////////////////////////////////////////////////////
   // Clock tree selects
   ref_on_a: assert property (reference_on == (reference_divider_code != REF_OFF))
      else $error("reference on wrong");
   out_onehot_a: assert property ($onehot0(multiplied_clock_select))
      else $error("output select not one-hot");
   bypass_shift_a: assert property (system_scaler_bypass |-> !system_scaler_shift)
      else $error("shift set in bypass");
   sel_quiet_a: assert property ($changed({reference_divider_code,
      multiplied_clock_select, system_scaler_shift, system_scaler_bypass})
      |-> !system_clock_run)
      else $error("select changed while running");
   run_gap_a: assert property ($fell(system_clock_run) |-> !system_clock_run [*8])
      else $error("switch gap too short");
   run_bound_a: assert property ($fell(system_clock_run) |-> ##[20:60] system_clock_run)
      else $error("switch did not finish");
   // Main scenarios
   cov_read: cover property (take && !hwrite);
   cov_switch: cover property ($rose(system_clock_run));
   cov_irq: cover property ($fell(irq_pin));
endmodule
bind ckgsel_top ckgsel_chk u_chk (.clk_sys, .nrst, .hsel, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .reference_divider_code, .reference_on,
   .multiplied_clock_select, .system_scaler_shift, .system_scaler_bypass,
   .system_clock_run, .irq_pin);

// [sim/test_clock_select_enable_irq_gating.sv]
// Self-checking bench for the clock select and interrupt gating block.
// Assumes the bench is the only bus master and drives the event inputs.
`timescale 1ns/1ps
module test_clock_select_enable_irq_gating
   import ckgsel_pkg::*;
;
   logic        clk_sys, nrst, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, reference_divider_code, system_scaler_shift;
   logic [2:0]  hsize;
   logic [3:0]  ev;
   logic [4:0]  multiplied_clock_select;
   logic        reference_on, system_scaler_bypass, system_clock_run;
   logic        left_path_enable, right_path_enable, irq_pin;
   int          failures, checked;
   int          srcpos[4] = '{0, 2, 3, 4};
   logic [31:0] gate[3] = '{32'h0000_0000, 32'h0000_007F, 32'h0000_7F00};

   // Design under test; the lone slave drives hready
   ckgsel_top DUT (.clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .shutdown_event(ev[3]), .clipping_event(ev[2]),
      .undervoltage_event(ev[1]), .powerup_event(ev[0]),
      .reference_divider_code, .reference_on, .multiplied_clock_select,
      .system_scaler_shift, .system_scaler_bypass, .system_clock_run,
      .left_path_enable, .right_path_enable, .irq_pin);

   ////////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////
   // Verdict and comparison
   task automatic finish_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Bounded wait for a level, sampled at the rising edge
   task automatic wait_sig(ref logic s, input logic lvl, input int lim);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (s !== lvl && n < lim);
      if (s !== lvl)
      begin
         failures++;
         finish_test();
      end
   endtask
   // One AHB-Lite single word transfer; read data lands in rd
   task automatic xfer(input logic wr, input logic [9:0] idx,
                       input logic [31:0] wd);
      haddr  <= {20'h0_0000, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_sig(hreadyout, 1'b1, 50);
      htrans <= 2'h0;
      hwdata <= wd;
      wait_sig(hreadyout, 1'b1, 50);
      rd = hrdata;
   endtask
   // Whole clock switch: run drops, then returns
   task automatic switch_done();
      wait_sig(system_clock_run, 1'b0, 10);
      wait_sig(system_clock_run, 1'b1, 100);
   endtask
   // Expected one-hot output select
   function automatic logic [4:0] exp_sel(input int o, input logic men);
      case (o)
         0: return 5'h01;
         1: return 5'h02;
         2: return 5'h04;
         3: return men ? 5'h08 : 5'h00;
         4: return men ? 5'h10 : 5'h00;
         default: return 5'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {nrst, hwrite, haddr, hwdata, htrans, ev} = '0;
      hsel = 1'b1;
      hsize = 3'h2;
      failures = 0;
      checked = 0;
      tick(5);
      nrst <= 1'b1;
      check("irq idle", irq_pin, 1);
      check("left off", left_path_enable, 0);
      check("out sel", multiplied_clock_select, 5'h01);
      xfer(1, 10'h007, 32'h0000_FFFF);
      foreach (srcpos[i])
      begin
         xfer(0, 10'(i + 3), 32'h0000_0000);
         check("reset rd", rd, i == 2 ? 32'h0000_007F : 0);
      end
      // Output path enables
      for (int i = 0; i < 4; i++)
      begin
         xfer(1, CHANNEL_ENABLE_IDX, 32'(i));
         tick(3);
         check("left", left_path_enable, i / 2);
         check("right", right_path_enable, i % 2);
      end
      // Every reference code, and output and scaler codes 1 to 7
      for (int i = 1; i < 8; i++)
      begin
         xfer(1, CLOCK_TREE_SELECT_IDX, 32'((i % 4) << 8 | i << 4 | i));
         switch_done();
         check("ref code", reference_divider_code, i % 4);
         check("ref on", reference_on, i % 4 != 3);
         check("out sel", multiplied_clock_select, exp_sel(i, 0));
         check("shift", system_scaler_shift, i < 4 ? i : 0);
         check("bypass", system_scaler_bypass, i > 3);
      end
      xfer(1, MULTIPLIER_CTRL_IDX, 32'h0000_0001);
      switch_done();
      for (int o = 3; o < 5; o++)
      begin
         xfer(1, CLOCK_TREE_SELECT_IDX, 32'(o << 4 | 1 << 8));
         switch_done();
         check("mult sel", multiplied_clock_select, exp_sel(o, 1));
         check("mult ref", reference_divider_code, 1);
      end
      // Each source enabled, disabled, masked
      for (int k = 0; k < 4; k++)
         for (int m = 0; m < 3; m++)
         begin
            xfer(1, INTERRUPT_GATING_IDX, gate[m]);
            ev[k] <= 1'b1;
            tick(8);
            check("irq pin", irq_pin, m != 0);
            xfer(0, IRQ_FLAG_CLEAR_IDX, 0);
            check("status", rd, m == 1 ? 0 : 1 << srcpos[k]);
            ev[k] <= 1'b0;
            xfer(1, IRQ_FLAG_CLEAR_IDX, 32'h0000_007F);
            tick(3);
            check("cleared", irq_pin, 1);
            xfer(0, IRQ_FLAG_CLEAR_IDX, 0);
            check("clr status", rd, 0);
         end
      // Active-high interrupt output
      xfer(1, IRQ_CONTROL_IDX, 32'h0000_0001);
      tick(3);
      check("pol idle", irq_pin, 0);
      xfer(0, IRQ_CONTROL_IDX, 0);
      check("pol reg", rd, 1);
      xfer(1, INTERRUPT_GATING_IDX, 32'h0000_0000);
      ev[0] <= 1'b1;
      tick(8);
      check("pol active", irq_pin, 1);
      finish_test();
   end
endmodule
